// ==== elt_map.svh ====
`ifndef ELT_MAP_SVH
`define ELT_MAP_SVH
`define ELT_CODE_PRLI 8'h20
`define ELT_CODE_TPRLO 8'h24
`define ELT_CODE_GAID 8'h30
`define ELT_CODE_NDACT 8'h34
`define ELT_CODE_QOSR 8'h40
`define ELT_CODE_RVCS 8'h41
`define ELT_CODE_PDISC 8'h50
`define ELT_CODE_ADISC 8'h52
`define ELT_CODE_RNC 8'h53
`define ELT_CODE_RTV 8'h0E
`define ELT_CODE_LS_RJT 8'h01
`define ELT_CODE_ACC 8'h02
`define ELT_RTV_WORD 32'h0E000000
`define ELT_ACC_HDR 32'h02000000
`define ELT_FABRIC_ID 24'h0FFFFE
`define ELT_RES_BIT 26
`define ELT_ACC_WORDS 3'h4
`define ELT_NS_PER_MS 32'h000F4240
`endif

// ==== elt_pkg.sv ====
package elt_pkg;
  typedef enum logic [4:0] {
    ELT_CMD_RESERVED, ELT_CMD_RTV, ELT_CMD_PRLI, ELT_CMD_PRLO, ELT_CMD_SCN, ELT_CMD_TPLS, ELT_CMD_TPRLO,
    ELT_CMD_GAID, ELT_CMD_FACT, ELT_CMD_FDACT, ELT_CMD_NACT, ELT_CMD_NDACT, ELT_CMD_QOSR, ELT_CMD_RVCS,
    ELT_CMD_PDISC, ELT_CMD_FDISC, ELT_CMD_ADISC, ELT_CMD_RNC
  } elt_cmd_e;
  typedef enum logic [1:0] {ELT_IDLE, ELT_CHECK, ELT_SEND} elt_state_e;
endpackage

// ==== elt_decode.sv ====
`timescale 1ns/1ps
`include "elt_map.svh"
module elt_decode
  import elt_pkg::*;
(
  input wire logic [7:0] code,
  output elt_cmd_e cmd
);
  always_comb begin
    cmd = ELT_CMD_RESERVED;
    if (code == `ELT_CODE_RTV) begin
      cmd = ELT_CMD_RTV;
    end else if (code >= `ELT_CODE_PRLI && code <= `ELT_CODE_TPRLO) begin
      cmd = elt_cmd_e'(5'(ELT_CMD_PRLI) + 5'(code - `ELT_CODE_PRLI)); // R1
    end else if (code >= `ELT_CODE_GAID && code <= `ELT_CODE_NDACT) begin
      cmd = elt_cmd_e'(5'(ELT_CMD_GAID) + 5'(code - `ELT_CODE_GAID)); // R1
    end else if (code == `ELT_CODE_QOSR) begin
      cmd = ELT_CMD_QOSR; // R2
    end else if (code == `ELT_CODE_RVCS) begin
      cmd = ELT_CMD_RVCS; // R2
    end else if (code >= `ELT_CODE_PDISC && code <= `ELT_CODE_ADISC) begin
      cmd = elt_cmd_e'(5'(ELT_CMD_PDISC) + 5'(code - `ELT_CODE_PDISC)); // R3
    end else if (code == `ELT_CODE_RNC) begin
      cmd = ELT_CMD_RNC; // R3
    end
  end
endmodule

// ==== elt_timeout_query.sv ====
// Behaviour
// R1: codes 20-24, 30-34 decode to process/alias commands
// R2: code 40 is QoSR, 41 is RVCS
// R3: 50-52 discover commands, 53 RNC, rest reserved
// R4: refused RTV gets LS_RJT, honoured gets ACC
// R5: RTV may target this port or fabric
// R6: requester sends single word 0E000000
// R7: accept is header, R_A_TOV, E_D_TOV, qualifier
// R8: qualifier bit 26 selects ms or ns
// R9: point-to-point R_A_TOV uses E_D_TOV resolution
// R10: other topologies report R_A_TOV in ms
// R11: requester fills source and destination IDs
// R12: timeout values latched when request decoded
`timescale 1ns/1ps
`include "elt_map.svh"
module elt_timeout_query
  import elt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [31:0] req_word,
  input wire logic req_last,
  input wire logic [23:0] req_d_id,
  input wire logic [23:0] req_s_id,
  output logic req_ready,
  input wire logic [23:0] own_port_id,
  input wire logic is_fabric_port,
  input wire logic point_to_point,
  input wire logic cfg_ns_res,
  input wire logic [31:0] cfg_r_a_tov_ms,
  input wire logic [31:0] cfg_e_d_tov,
  output elt_cmd_e cmd_code,
  output logic cmd_valid,
  output logic [23:0] rsp_d_id,
  output logic rsp_valid,
  output logic [31:0] rsp_word,
  output logic rsp_last,
  input wire logic rsp_ready
);
  typedef struct packed {
    elt_state_e state;
    logic [2:0] words;
    logic bad;
    logic accept;
    logic [2:0] idx;
    logic [31:0] ratov;
    logic [31:0] edtov;
    logic ns_res;
    logic [23:0] peer;
    elt_cmd_e cmd;
    logic cmd_valid;
    logic [31:0] word;
    logic last;
  } elt_s;

  elt_s q;
  elt_s next_q;
  elt_cmd_e dec_cmd;
  logic [31:0] ratov_sel;

  elt_decode u_decode (
    .code(req_word[31:24]),
    .cmd(dec_cmd)
  );

  // R9 R10: ns ratov only in point-to-point
  assign ratov_sel = (point_to_point && cfg_ns_res) ? 32'(cfg_r_a_tov_ms * `ELT_NS_PER_MS) : cfg_r_a_tov_ms;

  assign req_ready = (q.state == ELT_IDLE) || (q.state == ELT_CHECK);
  assign rsp_valid = (q.state == ELT_SEND);
  assign rsp_word = q.word;
  assign rsp_last = q.last;
  assign rsp_d_id = q.peer;
  assign cmd_code = q.cmd;
  assign cmd_valid = q.cmd_valid;

  function automatic logic [31:0] acc_word(input logic [2:0] i, input elt_s s);
    logic [31:0] w;
    w = '0;
    unique case (i)
      3'h0: w = `ELT_ACC_HDR; // R7
      3'h1: w = s.ratov; // R7
      3'h2: w = s.edtov; // R7
      default: w[`ELT_RES_BIT] = s.ns_res; // R8
    endcase
    return w;
  endfunction

  always_comb begin
    next_q = q;
    next_q.cmd_valid = 1'b0;
    unique case (q.state)
      ELT_IDLE: begin
        if (req_valid) begin
          next_q.cmd = dec_cmd;
          next_q.cmd_valid = 1'b1;
          if (dec_cmd == ELT_CMD_RTV) begin
            next_q.peer = req_s_id; // R11
            next_q.bad = (req_word != `ELT_RTV_WORD) || // R6
              !((req_d_id == own_port_id) || (is_fabric_port && req_d_id == `ELT_FABRIC_ID)); // R5
            next_q.words = 3'h1;
            next_q.ratov = ratov_sel; // R12
            next_q.edtov = cfg_e_d_tov; // R12
            next_q.ns_res = cfg_ns_res; // R12
            if (req_last) begin
              next_q.accept = !next_q.bad; // R4
              next_q.idx = 3'h0;
              next_q.word = next_q.bad ? {`ELT_CODE_LS_RJT, 24'h000000} : `ELT_ACC_HDR; // R4
              next_q.last = next_q.bad;
              next_q.state = ELT_SEND;
            end else begin
              next_q.state = ELT_CHECK;
            end
          end
        end
      end
      ELT_CHECK: begin
        if (req_valid) begin
          next_q.bad = 1'b1; // R6
          if (req_last) begin
            next_q.accept = 1'b0;
            next_q.word = {`ELT_CODE_LS_RJT, 24'h000000}; // R4
            next_q.last = 1'b1;
            next_q.state = ELT_SEND;
          end
        end
      end
      ELT_SEND: begin
        if (rsp_ready) begin
          if (q.last) begin
            next_q.state = ELT_IDLE;
          end else begin
            next_q.idx = q.idx + 3'h1;
            next_q.word = acc_word(3'(q.idx + 3'h1), q); // R7
            next_q.last = (3'(q.idx + 3'h2) == `ELT_ACC_WORDS);
          end
        end
      end
      default: next_q.state = ELT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// ==== elt_timeout_query_asserts.sv ====
`timescale 1ns/1ps
module elt_timeout_query_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [31:0] req_word,
  input wire logic req_last,
  input wire logic req_ready,
  input wire logic cfg_ns_res,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_word,
  input wire logic rsp_last,
  input wire logic rsp_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_CODE: assert property ($rose(rsp_valid) |-> rsp_word[31:24] inside {8'h01, 8'h02})
    else $error("reply code");
  AST_RJT: assert property ($rose(rsp_valid) && rsp_word[31:24] == 8'h01 |-> rsp_last)
    else $error("reject length");
  AST_ANS: assert property (req_valid && req_ready && req_last && req_word == 32'h0E000000 |=> rsp_valid)
    else $error("no reply");
  AST_HDR: assert property ($rose(rsp_valid) && rsp_word == 32'h02000000 ##0 rsp_ready [*3] |-> !rsp_last ##1 rsp_last)
    else $error("accept length");
  AST_QUAL: assert property (rsp_valid && rsp_last && rsp_word[31:24] != 8'h01 |-> rsp_word == {5'h0, cfg_ns_res, 26'h0})
    else $error("qualifier");
  AST_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_word) && $stable(rsp_last))
    else $error("word moved");
  AST_BUSY: assert property (rsp_valid |-> !req_ready)
    else $error("ready while sending");
  AST_END: assert property (rsp_valid && rsp_ready && rsp_last |=> !rsp_valid)
    else $error("reply too long");
endmodule
bind elt_timeout_query elt_timeout_query_asserts chk_i (.*);

// ==== elt_sink.sv ====
`timescale 1ns/1ps
module elt_sink (
  input wire logic clk,
  input wire logic slow,
  output logic rsp_ready
);
  logic [1:0] n = 2'h0;
  always @(posedge clk) n <= n + 2'h1;
  // when slow, takes one word in four
  assign rsp_ready = !slow || n == 2'h3;
endmodule

// ==== elt_timeout_query_tb.sv ====
`timescale 1ns/1ps
module elt_timeout_query_tb;
  import elt_pkg::*;
  logic clk = 0, rst = 1, req_valid = 0, req_last = 0, is_fabric_port = 1, point_to_point = 0;
  logic cfg_ns_res = 0, slow = 0, req_ready, cmd_valid, rsp_valid, rsp_last, rsp_ready;
  logic [23:0] req_d_id = '0, req_s_id = 24'h0A0B0C, own_port_id = 24'h010203, rsp_d_id;
  logic [31:0] req_word = '0, cfg_r_a_tov_ms = 32'h0000000A, cfg_e_d_tov = 32'h000007D0, rsp_word;
  elt_cmd_e cmd_code;
  int mismatches = 0, checks = 0;
  always #2.5 clk = ~clk;
  elt_timeout_query dut (.*);
  elt_sink peer (.*);
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic send(logic [31:0] w);
    req_valid = 1;
    req_word = w;
    req_last = 1;
    @(negedge clk);
    req_valid = 0;
  endtask
  task automatic get(logic [31:0] e[$]);
    int n = 0;
    for (int t = 0; t < 40 && n < e.size(); t++) begin
      if (rsp_valid === 1'b1) chk("ready", req_ready, 0);
      if ((rsp_valid & rsp_ready) === 1'b1) begin
        chk("word", rsp_word, e[n]);
        chk("last", rsp_last, n == e.size() - 1);
        n++;
      end
      @(negedge clk);
    end
    chk("count", n, e.size());
    chk("idle", rsp_valid, 0);
  endtask
  task automatic rtv(logic p, logic s, logic [23:0] d, logic [31:0] w, logic acc);
    logic [31:0] ra = p && s ? cfg_r_a_tov_ms * 32'h000F4240 : cfg_r_a_tov_ms;
    logic [31:0] ed = cfg_e_d_tov;
    point_to_point = p;
    cfg_ns_res = s;
    req_d_id = d;
    send(w);
    cfg_e_d_tov = ed + 1;
    if (acc) get('{32'h02000000, ra, ed, {5'h0, s, 26'h0}});
    else get('{32'h01000000});
    chk("d_id", {8'h0, rsp_d_id}, {8'h0, req_s_id});
    $display("rtv done");
  endtask
  task automatic t_dec();
    logic [7:0] c[18] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
      8'h40, 8'h41, 8'h50, 8'h51, 8'h52, 8'h53, 8'h25, 8'h54};
    for (int i = 0; i < 18; i++) begin
      send({c[i], 24'h0});
      chk("valid", cmd_valid, 1);
      chk("cmd", cmd_code, i < 16 ? i + 2 : 0);
      chk("reply", rsp_valid, 0);
      @(negedge clk);
    end
    $display("decode done");
  endtask
  initial begin
    repeat (8) @(negedge clk);
    chk("reset", {rsp_valid, cmd_valid}, 0);
    rst = 0;
    t_dec();
    rtv(0, 0, own_port_id, 32'h0E000000, 1);
    rtv(0, 1, own_port_id, 32'h0E000000, 1);
    slow = 1;
    rtv(1, 1, own_port_id, 32'h0E000000, 1);
    rtv(0, 0, 24'h0FFFFE, 32'h0E000000, 1);
    rtv(0, 0, 24'h0A0B0D, 32'h0E000000, 0);
    rtv(0, 0, own_port_id, 32'h0E000001, 0);
    finish_test();
  end
  initial begin
    #5000;
    mismatches++;
    finish_test();
  end
endmodule
